// File: eoem_pkg.sv
// constants and carrier types of the e1 overhead event monitor
//------------------------------------------------------------
// Summary of operation
// RQ1 - mode0: twelve sa6 bits versus five patterns
// RQ2 - mode1: three sa6 codewords versus same patterns
// RQ3 - debounce control bit, resets to disabled
// RQ4 - debounce needs two equal sub-multiframes; hold unsynced
// RQ5 - special-pattern flag shows current match result
// RQ6 - special-pattern enable gates flag onto interrupt
// RQ7 - codeword change sets its channel change flag
// RQ8 - five change enables, reset zero, gate interrupt
// RQ9 - a one, e zero for 10ms: status
// RQ10 - 990 e zeros per second, five seconds
// RQ11 - two of three sa7 bits zero: link
// RQ12 - any status transition sets sticky change flag
// RQ13 - sa6 codeword 0010 or 0011: nt crc
// RQ14 - sa6 codeword 0001 or 0011: nt febe
// RQ15 - e bit zero in sync: febe event
// RQ16 - febe detection suspended while crc unsynced
// RQ17 - writing one clears flag, zero keeps
// RQ18 - five overhead enables gate interrupt, reset zero
// RQ19 - nt crc enable gates its flag
// RQ20 - interrupt while any enabled flag is set
//------------------------------------------------------------
package eoem_pkg;
	// register indices; byte address is four times the index
	localparam logic [9:0] NAT_CTRL_IDX = 10'h05c;
	localparam logic [9:0] NAT_FLAG_IDX = 10'h05d;
	localparam logic [9:0] OVH_STAT_IDX = 10'h05f;
	localparam logic [9:0] OVH_CTRL_IDX = 10'h060;
	localparam logic [9:0] OVH_FLAG_IDX = 10'h061;
	localparam logic [9:0] CW_STORE_IDX = 10'h070;
	localparam logic [7:0] REG_RST = 8'h00;
	// national control and flag field positions
	localparam int CTL_MODE_BIT = 7;
	localparam int CTL_DEB_BIT = 6;
	localparam int CTL_SP_EN_BIT = 5;
	localparam int SP_FLAG_BIT = 5;
	// overhead flag / enable positions
	localparam int OF_NT_CRC = 5;
	localparam int OF_NT_FEBE = 4;
	localparam int OF_FEBE = 3;
	localparam int OF_CONT_AF = 2;
	localparam int OF_CONT_FEBE = 1;
	localparam int OF_LINK = 0;
	// overhead status positions
	localparam int ST_CONT_AF = 4;
	localparam int ST_CONT_FEBE = 3;
	localparam int ST_LINK = 2;
	// channel index within sa vectors: 4=sa4 ... 0=sa8
	localparam int CH_SA6 = 2;
	localparam int CH_SA7 = 1;
	// special patterns and nt codes
	localparam logic [11:0] PAT_888 = 12'h888;
	localparam logic [11:0] PAT_AAA = 12'haaa;
	localparam logic [11:0] PAT_CCC = 12'hccc;
	localparam logic [11:0] PAT_EEE = 12'heee;
	localparam logic [11:0] PAT_FFF = 12'hfff;
	localparam logic [3:0] NT_CRC_A = 4'h2;
	localparam logic [3:0] NT_CRC_B = 4'h3;
	localparam logic [3:0] NT_FEBE_A = 4'h1;
	localparam logic [3:0] NT_FEBE_B = 4'h3;
	// timing
	localparam int CLK_HZ = 125_000_000;
	localparam int CONT_AF_TIME_MS = 10;
	localparam int CONT_AF_CYC = CLK_HZ / 1000 * CONT_AF_TIME_MS;
	localparam int SEC_TIME_S = 1;
	localparam int SEC_CYC = CLK_HZ * SEC_TIME_S;
	localparam logic [10:0] FEBE_MIN = 11'd990;
	localparam int CFEBE_SECS = 5;

	// receive overhead from the framer, same clock
	typedef struct packed {
		logic basic_sync;
		logic crc_sync;
		logic nfas_stb;
		logic a_bit;
		logic [4:0] sa;
		logic smf_end;
		logic e_stb;
		logic e_bit;
	} eoem_ovh_t;
endpackage

// File: eoem_monitor.sv
// e1 receive overhead event monitor with apb register slave
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
module eoem_monitor import eoem_pkg::*; #(
	parameter int CONT_AF_CYCLES = CONT_AF_CYC,
	parameter int SEC_CYCLES = SEC_CYC
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire eoem_ovh_t ovh_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	output logic irq_o
);
	if (CONT_AF_CYCLES < 1 || SEC_CYCLES < 2) begin : g_chk
		$error("eoem_monitor: timing counts too small");
	end

	localparam int AW = $clog2(CONT_AF_CYCLES + 1);
	localparam int SW = $clog2(SEC_CYCLES + 1);

	//------------------------------------------------------------
	// apb decode
	//------------------------------------------------------------
	logic [7:0] nat_ctrl_r, nat_flag_r, ovh_ctrl_r, ovh_flag_r;
	logic [7:0] ovh_stat;
	logic [19:0] cw_all;
	logic [31:0] prdata_r, rd_mux;
	logic pready_r, pslverr_r, irq_r;
	wire [9:0] idx = paddr_i[11:2];
	wire acc = psel_i & penable_i;
	wire done = acc & pready_r;
	wire wr = done & pwrite_i;
	wire hit = (idx == NAT_CTRL_IDX) | (idx == NAT_FLAG_IDX) |
		(idx == OVH_STAT_IDX) | (idx == OVH_CTRL_IDX) |
		(idx == OVH_FLAG_IDX) | (idx == CW_STORE_IDX);
	wire wr_nat_ctrl = wr & (idx == NAT_CTRL_IDX);
	wire wr_ovh_ctrl = wr & (idx == OVH_CTRL_IDX);
	// RQ17 w1c strobes
	wire [7:0] clr_nat = (wr & (idx == NAT_FLAG_IDX)) ? pwdata_i[7:0] : 8'h00;
	wire [7:0] clr_ovh = (wr & (idx == OVH_FLAG_IDX)) ? pwdata_i[7:0] : 8'h00;

	always_comb begin
		rd_mux = 32'h0000_0000;
		case (idx)
			NAT_CTRL_IDX: rd_mux = {24'h000000, nat_ctrl_r};
			NAT_FLAG_IDX: rd_mux = {24'h000000, nat_flag_r};
			OVH_STAT_IDX: rd_mux = {24'h000000, ovh_stat};
			OVH_CTRL_IDX: rd_mux = {24'h000000, ovh_ctrl_r};
			OVH_FLAG_IDX: rd_mux = {24'h000000, ovh_flag_r};
			CW_STORE_IDX: rd_mux = {12'h000, cw_all};
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// one wait state: pready rises in the second access cycle
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
		end else begin
			pready_r <= acc & ~pready_r;
			pslverr_r <= acc & ~pready_r & ~hit;
			if (acc & ~pready_r & ~pwrite_i)
				prdata_r <= rd_mux;
		end
	end

	//------------------------------------------------------------
	// control registers
	//------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			// RQ3 debounce off
			nat_ctrl_r <= REG_RST;
			// RQ18 enables reset zero
			ovh_ctrl_r <= REG_RST;
		end else begin
			if (wr_nat_ctrl)
				nat_ctrl_r <= pwdata_i[7:0];
			if (wr_ovh_ctrl)
				ovh_ctrl_r <= {2'b00, pwdata_i[5:0]};
		end
	end
	wire mode = nat_ctrl_r[CTL_MODE_BIT];
	wire deb_en = nat_ctrl_r[CTL_DEB_BIT];
	wire crc_ok = ovh_i.crc_sync;
	wire nfas = ovh_i.nfas_stb;
	wire smf = ovh_i.smf_end & crc_ok;

	//------------------------------------------------------------
	// codeword extraction per channel
	//------------------------------------------------------------
	logic [3:0] sh_r [5];
	logic [3:0] prev_r [5];
	logic [3:0] cw_r [5];
	logic [4:0] chg_set;
	for (genvar c = 0; c < 5; c++) begin : g_ch
		// RQ4 debounce needs matching previous raw word
		wire upd = smf & (~deb_en | (sh_r[c] == prev_r[c]));
		// RQ7 change of stored word
		assign chg_set[c] = upd & (sh_r[c] != cw_r[c]);
		always_ff @(posedge clk_i) begin
			if (!rst_n_i) begin
				sh_r[c] <= 4'h0;
				prev_r[c] <= 4'h0;
				cw_r[c] <= 4'h0;
			end else begin
				if (nfas & crc_ok)
					sh_r[c] <= {sh_r[c][2:0], ovh_i.sa[c]};
				if (smf)
					prev_r[c] <= sh_r[c];
				if (upd)
					cw_r[c] <= sh_r[c];
			end
		end
	end
	assign cw_all = {cw_r[4], cw_r[3], cw_r[2], cw_r[1], cw_r[0]};
	wire [3:0] raw6 = sh_r[CH_SA6];

	//------------------------------------------------------------
	// sa6 special pattern compare
	//------------------------------------------------------------
	function automatic logic pat_hit(input logic [11:0] v);
		pat_hit = (v == PAT_888) | (v == PAT_AAA) | (v == PAT_CCC) |
			(v == PAT_EEE) | (v == PAT_FFF);
	endfunction
	logic [11:0] sp_bits_r, sp_cw_r;
	logic sp_flag_r;
	wire [11:0] sp_bits_nxt = {sp_bits_r[10:0], ovh_i.sa[CH_SA6]};
	wire [11:0] sp_cw_nxt = {sp_cw_r[7:0], raw6};
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			sp_bits_r <= 12'h000;
			sp_cw_r <= 12'h000;
			sp_flag_r <= 1'b0;
		end else begin
			if (nfas & crc_ok)
				sp_bits_r <= sp_bits_nxt;
			if (smf)
				sp_cw_r <= sp_cw_nxt;
			// RQ1 bitwise window
			if (~mode & nfas & crc_ok)
				sp_flag_r <= pat_hit(sp_bits_nxt);
			// RQ2 codeword window
			else if (mode & smf)
				sp_flag_r <= pat_hit(sp_cw_nxt);
		end
	end

	//------------------------------------------------------------
	// continuous alarm and febe
	//------------------------------------------------------------
	logic a_last_r, e_zero_r, cont_af_r;
	logic [AW-1:0] af_cnt_r;
	wire af_cond = crc_ok & a_last_r & e_zero_r;
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			a_last_r <= 1'b0;
			e_zero_r <= 1'b0;
			af_cnt_r <= '0;
			cont_af_r <= 1'b0;
		end else begin
			if (nfas)
				a_last_r <= ovh_i.a_bit;
			if (ovh_i.e_stb)
				e_zero_r <= ~ovh_i.e_bit;
			// RQ9 held 10ms
			if (!af_cond) begin
				af_cnt_r <= '0;
				cont_af_r <= 1'b0;
			end else if (af_cnt_r == AW'(CONT_AF_CYCLES - 1)) begin
				cont_af_r <= 1'b1;
			end else begin
				af_cnt_r <= af_cnt_r + 1'b1;
			end
		end
	end

	logic [SW-1:0] sec_cnt_r;
	logic [10:0] ez_cnt_r;
	logic [CFEBE_SECS-1:0] sec_ok_r;
	logic cont_febe_r;
	// RQ16 no febe while unsynced
	wire febe_ev = crc_ok & ovh_i.e_stb & ~ovh_i.e_bit;
	wire sec_end = (sec_cnt_r == SW'(SEC_CYCLES - 1));
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			sec_cnt_r <= '0;
			ez_cnt_r <= 11'h000;
			sec_ok_r <= '0;
			cont_febe_r <= 1'b0;
		end else begin
			sec_cnt_r <= sec_end ? '0 : sec_cnt_r + 1'b1;
			if (!crc_ok) begin
				ez_cnt_r <= 11'h000;
				sec_ok_r <= '0;
			end else if (sec_end) begin
				ez_cnt_r <= 11'h000;
				// RQ10 per-second count check
				sec_ok_r <= {sec_ok_r[CFEBE_SECS-2:0],
					({1'b0, ez_cnt_r} + {11'h000, febe_ev}) >= {1'b0, FEBE_MIN}};
			end else if (febe_ev & ~&ez_cnt_r) begin
				ez_cnt_r <= ez_cnt_r + 1'b1;
			end
			cont_febe_r <= crc_ok & (&sec_ok_r);
		end
	end

	//------------------------------------------------------------
	// link id on sa7
	//------------------------------------------------------------
	logic [1:0] s7_r;
	logic link_r;
	wire [2:0] s7_win = {s7_r, ovh_i.sa[CH_SA7]};
	// RQ11 two of three zeros
	wire s7_two0 = (~s7_win[0] & ~s7_win[1]) | (~s7_win[0] & ~s7_win[2]) |
		(~s7_win[1] & ~s7_win[2]);
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			s7_r <= 2'b11;
			link_r <= 1'b0;
		end else if (!ovh_i.basic_sync) begin
			link_r <= 1'b0;
		end else if (nfas) begin
			s7_r <= s7_win[1:0];
			link_r <= s7_two0;
		end
	end
	assign ovh_stat = {3'b000, cont_af_r, cont_febe_r, link_r, 2'b00};

	//------------------------------------------------------------
	// sticky flags and interrupt
	//------------------------------------------------------------
	logic cont_af_d_r, cont_febe_d_r, link_d_r;
	// RQ12 either-direction transitions
	wire [2:0] st_chg = {cont_af_r ^ cont_af_d_r,
		cont_febe_r ^ cont_febe_d_r, link_r ^ link_d_r};
	// RQ13 RQ14 nt codes
	wire nt_crc = smf & ((raw6 == NT_CRC_A) | (raw6 == NT_CRC_B));
	wire nt_febe = smf & ((raw6 == NT_FEBE_A) | (raw6 == NT_FEBE_B));
	// RQ15 febe event
	wire [7:0] ovh_set = {2'b00, nt_crc, nt_febe, febe_ev, st_chg};
	// RQ5 level flag sits on bit 5
	wire [7:0] nat_flag_nxt = {2'b00, sp_flag_r,
		(nat_flag_r[4:0] & ~clr_nat[4:0]) | chg_set};
	// RQ6 RQ8 RQ18 RQ19 enable gating
	wire any_irq = |(nat_flag_r[4:0] & nat_ctrl_r[4:0]) |
		(nat_flag_r[SP_FLAG_BIT] & nat_ctrl_r[CTL_SP_EN_BIT]) |
		|(ovh_flag_r[5:0] & ovh_ctrl_r[5:0]);
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			cont_af_d_r <= 1'b0;
			cont_febe_d_r <= 1'b0;
			link_d_r <= 1'b0;
			nat_flag_r <= REG_RST;
			ovh_flag_r <= REG_RST;
			irq_r <= 1'b0;
		end else begin
			cont_af_d_r <= cont_af_r;
			cont_febe_d_r <= cont_febe_r;
			link_d_r <= link_r;
			nat_flag_r <= nat_flag_nxt;
			// RQ17 set wins over clear
			ovh_flag_r <= (ovh_flag_r & ~clr_ovh) | ovh_set;
			// RQ20 registered interrupt
			irq_r <= any_irq;
		end
	end

	assign prdata_o = prdata_r;
	assign pready_o = pready_r;
	assign pslverr_o = pslverr_r;
	assign irq_o = irq_r;

	//------------------------------------------------------------
	// assertions
	//------------------------------------------------------------
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	property p_febe_set;
		crc_ok && ovh_i.e_stb && !ovh_i.e_bit |=> ovh_flag_r[OF_FEBE];
	endproperty
	a_febe_set: assert property (p_febe_set) // RQ15
		else $error("febe event not flagged");

	property p_febe_oos;
		!crc_ok && !ovh_flag_r[OF_FEBE] |=> !ovh_flag_r[OF_FEBE];
	endproperty
	a_febe_oos: assert property (p_febe_oos) // RQ16
		else $error("febe flagged out of crc sync");

	property p_nt_crc;
		smf && (raw6 == 4'h2 || raw6 == 4'h3) |=> ovh_flag_r[OF_NT_CRC];
	endproperty
	a_nt_crc: assert property (p_nt_crc) // RQ13
		else $error("nt crc code missed");

	property p_nt_febe;
		smf && (raw6 == 4'h1 || raw6 == 4'h3) |=> ovh_flag_r[OF_NT_FEBE];
	endproperty
	a_nt_febe: assert property (p_nt_febe) // RQ14
		else $error("nt febe code missed");

	property p_irq;
		(ovh_flag_r[OF_FEBE] && ovh_ctrl_r[OF_FEBE]) |=> irq_o;
	endproperty
	a_irq: assert property (p_irq) // RQ20
		else $error("enabled flag gave no interrupt");

	property p_irq_mask;
		nat_flag_r == 8'h00 && ovh_flag_r == 8'h00 |=> !irq_o;
	endproperty
	a_irq_mask: assert property (p_irq_mask) // RQ20
		else $error("interrupt without any flag");

	property p_link;
		ovh_i.basic_sync && nfas && s7_two0 ##1 ovh_i.basic_sync |-> link_r;
	endproperty
	a_link: assert property (p_link) // RQ11
		else $error("link id not detected");

	property p_debounce;
		deb_en && smf && sh_r[CH_SA6] != prev_r[CH_SA6]
			|=> cw_r[CH_SA6] == $past(cw_r[CH_SA6]);
	endproperty
	a_debounce: assert property (p_debounce) // RQ4
		else $error("codeword updated without debounce match");

	property p_chg;
		smf && !deb_en && sh_r[CH_SA6] != cw_r[CH_SA6]
			|=> nat_flag_r[CH_SA6];
	endproperty
	a_chg: assert property (p_chg) // RQ7
		else $error("codeword change not flagged");

	property p_w1c;
		wr && idx == OVH_FLAG_IDX && pwdata_i[OF_LINK] && !st_chg[0]
			|=> !ovh_flag_r[OF_LINK];
	endproperty
	a_w1c: assert property (p_w1c) // RQ17
		else $error("write one did not clear flag");

	c_febe: cover property (febe_ev ##1 irq_o);
	c_cont_af: cover property (!cont_af_r ##1 cont_af_r);
	c_link: cover property (!link_r ##1 link_r);
	c_special: cover property (!sp_flag_r ##1 sp_flag_r);
endmodule

// File: eoem_far_end.sv
// remote e1 terminal model driving the receive overhead strobes
`timescale 1ns/1ps
module eoem_far_end import eoem_pkg::*; (
	input wire logic clk_i,
	output eoem_ovh_t ovh_o
);
	initial begin
		ovh_o = '0;
	end

	// one strobe cycle; released data lines show the inverse, not a stale copy
	task automatic strobe(input logic nf, input logic se, input logic es,
		input logic a, input logic e, input logic [4:0] sa);
		@(posedge clk_i);
		ovh_o.nfas_stb <= nf;
		ovh_o.smf_end <= se;
		ovh_o.e_stb <= es;
		ovh_o.a_bit <= a;
		ovh_o.e_bit <= e;
		ovh_o.sa <= sa;
		@(posedge clk_i);
		ovh_o.nfas_stb <= 1'b0;
		ovh_o.smf_end <= 1'b0;
		ovh_o.e_stb <= 1'b0;
		ovh_o.a_bit <= ~a;
		ovh_o.e_bit <= ~e;
		ovh_o.sa <= ~sa;
	endtask

	// four nfas frames then the sub-multiframe end, first bit in msb
	task automatic send_smf(input logic a, input logic [19:0] cw);
		for (int i = 0; i < 4; i++) begin
			strobe(1'b1, 1'b0, 1'b0, a, 1'b0, {cw[19-i], cw[15-i], cw[11-i],
				cw[7-i], cw[3-i]});
		end
		strobe(1'b0, 1'b1, 1'b0, a, 1'b0, 5'h00);
	endtask

	task automatic ebit(input logic e);
		strobe(1'b0, 1'b0, 1'b1, 1'b0, e, 5'h00);
	endtask

	task automatic set_sync(input logic b, input logic c);
		@(posedge clk_i);
		ovh_o.basic_sync <= b;
		ovh_o.crc_sync <= c;
	endtask
endmodule

// File: tb_eoem_monitor.sv
// self-checking bench for the e1 overhead event monitor
`timescale 1ns/1ps
module tb_eoem_monitor import eoem_pkg::*; ;
	// short counts keep the run small
	localparam int AF_CYC = 50;
	localparam int S_CYC = 2000;
	logic clk_i = 1'b0;
	logic rst_n_i;
	logic psel;
	logic penable;
	logic pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic irq;
	logic [31:0] r;
	logic er;
	eoem_ovh_t ovh;
	int errors = 0;
	int n_checks = 0;
	logic [9:0] rst_idx[5] = '{NAT_CTRL_IDX, NAT_FLAG_IDX, OVH_STAT_IDX,
		OVH_CTRL_IDX, OVH_FLAG_IDX};
	logic [3:0] cds[4] = '{4'h2, 4'h3, 4'h1, 4'h0};
	logic [7:0] nex[4] = '{8'h20, 8'h30, 8'h10, 8'h00};

	always #4 clk_i = ~clk_i;

	eoem_far_end u_far (.clk_i(clk_i), .ovh_o(ovh));

	eoem_monitor #(.CONT_AF_CYCLES(AF_CYC), .SEC_CYCLES(S_CYC)) u_dut (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .ovh_i(ovh), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
		.pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .irq_o(irq));

	//------------------------------------------------------------
	// report and bus tasks
	//------------------------------------------------------------
	task automatic end_of_test();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			errors++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask

	task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		int n;
		n = 0;
		@(posedge clk_i);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= wd;
		@(posedge clk_i);
		penable <= 1'b1;
		do begin
			@(posedge clk_i);
			n++;
		end while (pready !== 1'b1 && n < 20);
		// a slave that never answers ends the run
		if (n >= 20) begin
			errors++;
			end_of_test();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [9:0] idx, input logic [31:0] d);
		apb(1'b1, idx, d, r, er);
		chk("slverr", 32'h0, {31'h0, er});
	endtask

	task automatic rdc(input logic [9:0] idx, input logic [31:0] m,
		input logic [31:0] e);
		apb(1'b0, idx, 32'h0, r, er);
		chk($sformatf("reg %h", idx), e, r & m);
		chk("slverr", 32'h0, {31'h0, er});
	endtask

	task automatic irqc(input logic e);
		repeat (3) @(posedge clk_i);
		chk("irq", {31'h0, e}, {31'h0, irq});
	endtask

	//------------------------------------------------------------
	// main sequence
	//------------------------------------------------------------
	initial begin
		rst_n_i <= 1'b0;
		psel <= 1'b0;
		penable <= 1'b0;
		pwrite <= 1'b0;
		paddr <= 12'h000;
		pwdata <= 32'h0;
		repeat (10) @(posedge clk_i);
		rst_n_i <= 1'b1;
		u_far.set_sync(1'b1, 1'b1);
		foreach (rst_idx[i]) rdc(rst_idx[i], '1, 32'h0);
		rdc(CW_STORE_IDX, '1, 32'h0);
		apb(1'b0, 10'h05e, 32'h0, r, er);
		chk("unmapped", 32'h1, {31'h0, er});
		wr(OVH_STAT_IDX, 32'hff);
		rdc(OVH_STAT_IDX, '1, 32'h0);
		// febe event, mask, write-one clear, suspension
		wr(OVH_CTRL_IDX, 32'h08);
		u_far.ebit(1'b0);
		irqc(1'b1);
		wr(OVH_FLAG_IDX, 32'h00);
		rdc(OVH_FLAG_IDX, '1, 32'h08);
		wr(OVH_FLAG_IDX, 32'h08);
		rdc(OVH_FLAG_IDX, '1, 32'h00);
		irqc(1'b0);
		u_far.set_sync(1'b1, 1'b0);
		u_far.ebit(1'b0);
		rdc(OVH_FLAG_IDX, '1, 32'h00);
		u_far.set_sync(1'b1, 1'b1);
		// nt codes, sa7 held at ones so the link stays idle
		wr(OVH_CTRL_IDX, 32'h30);
		for (int i = 0; i < 4; i++) begin
			u_far.send_smf(1'b0, {8'h00, cds[i], 8'hf0});
			rdc(OVH_FLAG_IDX, 32'h3f, {24'h0, nex[i]});
			irqc(nex[i] != 8'h00);
			wr(OVH_FLAG_IDX, 32'h30);
		end
		wr(NAT_FLAG_IDX, 32'h1f);
		// codeword change and store
		wr(NAT_CTRL_IDX, 32'h10);
		u_far.send_smf(1'b0, 20'h9a0e3);
		rdc(CW_STORE_IDX, '1, 32'h9a0e3);
		rdc(NAT_FLAG_IDX, 32'h1f, 32'h1b);
		irqc(1'b1);
		wr(NAT_FLAG_IDX, 32'h10);
		irqc(1'b0);
		// debounce needs two equal sub-multiframes
		wr(NAT_CTRL_IDX, 32'h40);
		wr(NAT_FLAG_IDX, 32'h1f);
		u_far.send_smf(1'b0, 20'h1a0e3);
		rdc(CW_STORE_IDX, '1, 32'h9a0e3);
		u_far.send_smf(1'b0, 20'h1a0e3);
		rdc(CW_STORE_IDX, '1, 32'h1a0e3);
		rdc(NAT_FLAG_IDX, 32'h1f, 32'h10);
		u_far.set_sync(1'b1, 1'b0);
		repeat (2) u_far.send_smf(1'b0, 20'h2a0e3);
		rdc(CW_STORE_IDX, '1, 32'h1a0e3);
		u_far.set_sync(1'b1, 1'b1);
		// special pattern over three codewords
		wr(NAT_CTRL_IDX, 32'ha0);
		wr(NAT_FLAG_IDX, 32'h1f);
		repeat (3) u_far.send_smf(1'b0, 20'h1a8e3);
		rdc(NAT_FLAG_IDX, 32'h3f, 32'h24);
		irqc(1'b1);
		u_far.send_smf(1'b0, 20'h1a0e3);
		rdc(NAT_FLAG_IDX, 32'h20, 32'h00);
		irqc(1'b0);
		// special pattern over twelve single bits, enable off
		wr(NAT_CTRL_IDX, 32'h00);
		repeat (3) u_far.send_smf(1'b0, 20'h1aee3);
		rdc(NAT_FLAG_IDX, 32'h20, 32'h20);
		irqc(1'b0);
		// link id over sliding sa7 bits
		wr(OVH_FLAG_IDX, 32'h3f);
		u_far.send_smf(1'b0, 20'h1a003);
		rdc(OVH_STAT_IDX, '1, 32'h04);
		rdc(OVH_FLAG_IDX, 32'h01, 32'h01);
		wr(OVH_FLAG_IDX, 32'h01);
		u_far.set_sync(1'b0, 1'b1);
		rdc(OVH_STAT_IDX, '1, 32'h00);
		rdc(OVH_FLAG_IDX, 32'h01, 32'h01);
		u_far.set_sync(1'b1, 1'b1);
		// continuous alarm with e zero
		u_far.send_smf(1'b1, 20'h1a0e3);
		u_far.ebit(1'b0);
		repeat (AF_CYC - 25) @(posedge clk_i);
		rdc(OVH_STAT_IDX, 32'h10, 32'h00);
		repeat (30) @(posedge clk_i);
		rdc(OVH_STAT_IDX, 32'h10, 32'h10);
		u_far.ebit(1'b1);
		rdc(OVH_STAT_IDX, 32'h10, 32'h00);
		rdc(OVH_FLAG_IDX, 32'h04, 32'h04);
		// about 1000 e zeros per short second
		repeat (4500) u_far.ebit(1'b0);
		rdc(OVH_STAT_IDX, 32'h08, 32'h00);
		repeat (3000) u_far.ebit(1'b0);
		rdc(OVH_STAT_IDX, 32'h08, 32'h08);
		rdc(OVH_FLAG_IDX, 32'h02, 32'h02);
		end_of_test();
	end
endmodule
